/* File: core/cpf_pkg.sv */
// package: constants, types and decoders of the cell protection fault controller
// Notes on behaviour
// - any cell over the overvoltage level turns charge off, discharge stays on
// - overvoltage clears on a latch clear toggle once every cell is below the level, no hysteresis
// - any cell under the undervoltage level turns discharge off, charge stays on
// - undervoltage clears on a latch clear toggle above level plus hysteresis, or above level with pack over battery
// - discharge overcurrent turns both switches off
// - short circuit turns both switches off; neither current fault recovers on its own
// - both switches stay off until the regulators are properly powered
// - regulators start from the pack input, then move to battery once both are stable
// - losing the three volt regulator shuts switches, regulators and thermistor drive
// - strap code 000 to 101 selects ten down to five cells
// - zero delay select high makes every detection delay zero
// - gain select picks the low or the high cell monitor reference and gain
// - a disabled cell voltage output is tied to ground
// - pack monitor enable routes scaled total pack voltage to the output
// - battery monitor enable routes scaled total battery voltage to the output while pack monitor enable is off
// - with amplifier on, both monitor enables off and no cell selected, the calibration code picks the source
package cpf_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;
  localparam int DLY_W = 8;
  localparam int NFAULT = 4;
  localparam int NEVT = 5;
  localparam int F_OV = 0;
  localparam int F_UV = 1;
  localparam int F_OCD = 2;
  localparam int F_SCD = 3;
  localparam int EV_PWR = 4;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_DELAY = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET = 32'h0a0a_0a0a;
  localparam logic [NEVT-1:0] MASK_RESET = 5'h00;
  localparam logic [2:0] CAL_AMP_ZERO = 3'h1;
  localparam logic [2:0] CAL_REF_AMP = 3'h2;
  localparam logic [2:0] CAL_REF_DIRECT = 3'h3;
  localparam logic [2:0] CAL_HI_AMP = 3'h4;
  localparam logic [2:0] CAL_REF_HOLD = 3'h5;
  localparam logic [2:0] CAL_HI_HOLD = 3'h6;
  localparam logic [2:0] STRAP_TEN = 3'h0;
  localparam logic [2:0] STRAP_FIVE = 3'h5;
  localparam logic [3:0] CELLS_MAX = 4'ha;
  localparam logic [3:0] CELLS_NONE = 4'h0;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_PACK = 2'b01,
    PWR_BAT = 2'b11
  } cpf_pwr_type;

  typedef enum logic [3:0] {
    VR_GROUND = 4'h0,
    VR_CELL = 4'h1,
    VR_PACK = 4'h2,
    VR_BAT = 4'h3,
    VR_AMP_ZERO = 4'h4,
    VR_REF_DIRECT = 4'h5,
    VR_REF_AMP = 4'h6,
    VR_HI_AMP = 4'h7,
    VR_REF_HOLD = 4'h8,
    VR_HI_HOLD = 4'h9
  } cpf_route_type;

  typedef struct packed {
    logic [16:0] spare;
    logic [3:0] cell_sel;
    logic [2:0] cal_sel;
    logic thermistor_drive_en;
    logic amp_en;
    logic bat_mon;
    logic pack_mon;
    logic gain_sel;
    logic latch_clear;
    logic dsg_en;
    logic chg_en;
  } cpf_ctrl_type;

  typedef struct packed {
    logic ov;
    logic ov_all_below;
    logic uv;
    logic uv_above_hyst;
    logic uv_above;
    logic pack_over_bat;
    logic discharge_overcurrent;
    logic discharge_short_circuit;
    logic pack_startup;
    logic five_volt_regulator_good;
    logic three_volt_regulator_good;
    logic [2:0] strap;
    logic zero_delay;
  } cpf_pins_type;

  // zero marks a reserved strap code
  function automatic logic [3:0] cpf_cell_count(input logic [2:0] strap);
    cpf_cell_count = (strap <= STRAP_FIVE) ? CELLS_MAX - {1'b0, strap} : CELLS_NONE;
  endfunction

  function automatic logic [31:0] cpf_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      cpf_merge[8*b+:8] = be[b] ? wd[8*b+:8] : old[8*b+:8];
    end
  endfunction
endpackage

/* File: core/cpf_fault_ctl.sv */
// top: protection fault control, power sequencing and monitor routing
`timescale 1ns/1ps
`default_nettype none
module cpf_fault_ctl
  import cpf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic cell_overvoltage_i,
  input wire logic ov_all_below_i,
  input wire logic cell_undervoltage_i,
  input wire logic uv_above_hyst_i,
  input wire logic uv_above_i,
  input wire logic pack_over_bat_i,
  input wire logic discharge_overcurrent_i,
  input wire logic discharge_short_circuit_i,
  input wire logic pack_startup_i,
  input wire logic five_volt_regulator_good_i,
  input wire logic three_volt_regulator_good_i,
  input wire logic cell_count_strap_high_i,
  input wire logic cell_count_strap_mid_i,
  input wire logic cell_count_strap_low_i,
  input wire logic zero_delay_select_i,
  output logic charge_switch_o,
  output logic discharge_switch_o,
  output logic five_volt_regulator_en_o,
  output logic three_volt_regulator_en_o,
  output logic reg_source_bat_o,
  output logic thermistor_drive_o,
  output var cpf_route_type vout_route_o,
  output logic [3:0] cell_select_o,
  output logic cell_gain_select_o,
  output logic irq_o
);
  cpf_pins_type pins_raw;
  cpf_pins_type sync1_reg;
  cpf_pins_type pins;
  cpf_ctrl_type ctrl_reg;
  cpf_ctrl_type ctrl_next;
  cpf_pwr_type pwr_reg;
  cpf_route_type route_next;
  logic [31:0] delay_reg;
  logic [NEVT-1:0] irq_status_reg;
  logic [NEVT-1:0] irq_mask_reg;
  logic [NEVT-1:0] event_vec;
  logic [NFAULT-1:0] fault_reg;
  logic [NFAULT-1:0] cond;
  logic [NFAULT-1:0] trip;
  logic [NFAULT-1:0] recov;
  logic [DLY_W-1:0] dly_cnt_reg [NFAULT];
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic clear_prev_reg;
  logic clr_pulse;
  logic req;
  logic access;
  logic [3:0] cell_count_reg;
  logic strap_reserved_reg;
  logic three_volt_regulator_lost;

  assign pins_raw = '{
    ov: cell_overvoltage_i, ov_all_below: ov_all_below_i,
    uv: cell_undervoltage_i, uv_above_hyst: uv_above_hyst_i,
    uv_above: uv_above_i, pack_over_bat: pack_over_bat_i,
    discharge_overcurrent: discharge_overcurrent_i, discharge_short_circuit: discharge_short_circuit_i,
    pack_startup: pack_startup_i, five_volt_regulator_good: five_volt_regulator_good_i,
    three_volt_regulator_good: three_volt_regulator_good_i,
    strap: {cell_count_strap_high_i, cell_count_strap_mid_i, cell_count_strap_low_i},
    zero_delay: zero_delay_select_i};

  // comparators and straps are analog, so every pin is resynchronised
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= '0;
      pins <= '0;
    end else begin
      sync1_reg <= pins_raw;
      pins <= sync1_reg;
    end
  end

  assign req = avs_read_i | avs_write_i;
  assign access = req & ~avs_waitrequest_o;

  // one wait cycle per access; read data is prepared during it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      unique case (avs_address_i)
        ADDR_CTRL: avs_readdata_o <= ctrl_reg;
        ADDR_STATUS: avs_readdata_o <= {18'h00000, charge_switch_o, discharge_switch_o,
                                        pwr_reg, pins.zero_delay, strap_reserved_reg,
                                        cell_count_reg, fault_reg};
        ADDR_DELAY: avs_readdata_o <= delay_reg;
        ADDR_IRQ_STATUS: avs_readdata_o <= {27'h0, irq_status_reg};
        ADDR_IRQ_MASK: avs_readdata_o <= {27'h0, irq_mask_reg};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      delay_reg <= DELAY_RESET;
      irq_mask_reg <= MASK_RESET;
    end else if (access && avs_write_i) begin
      if (avs_address_i == ADDR_DELAY) begin
        delay_reg <= cpf_merge(delay_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == ADDR_IRQ_MASK) begin
        // only the event lanes of the merged word are kept
        irq_mask_reg <= NEVT'(cpf_merge({27'h0, irq_mask_reg}, avs_writedata_i,
                                        avs_byteenable_i));
      end
    end
  end

  // host writes, then a new trip drops the matching enables so that the
  // switches come back only after an explicit re-enable
  always_comb begin
    ctrl_next = ctrl_reg;
    if (access && avs_write_i && avs_address_i == ADDR_CTRL) begin
      ctrl_next = cpf_merge(ctrl_reg, avs_writedata_i, avs_byteenable_i);
    end
    if (trip[F_OV] | trip[F_OCD] | trip[F_SCD]) begin
      ctrl_next.chg_en = 1'b0;
    end
    if (trip[F_UV] | trip[F_OCD] | trip[F_SCD]) begin
      ctrl_next.dsg_en = 1'b0;
    end
    ctrl_next.spare = '0;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (pwr_reg != PWR_BAT) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // fault latch clear acts on its falling edge, after a high phase
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clear_prev_reg <= 1'b0;
    end else begin
      clear_prev_reg <= ctrl_reg.latch_clear;
    end
  end
  assign clr_pulse = clear_prev_reg & ~ctrl_reg.latch_clear;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

  assign cond = {pins.discharge_short_circuit, pins.discharge_overcurrent, pins.uv, pins.ov};
  assign recov[F_OV] = pins.ov_all_below;
  assign recov[F_UV] = pins.uv_above_hyst | (pins.uv_above & pins.pack_over_bat);
  // no autonomous condition: the host toggle alone releases a current fault
  assign recov[F_OCD] = 1'b1;
  assign recov[F_SCD] = 1'b1;

  // current faults only clear by host toggle; the condition still present
  // re-trips at once since the set term wins
  for (genvar i = 0; i < NFAULT; i++) begin : g_fault
    logic [DLY_W-1:0] limit;
    assign limit = delay_reg[DLY_W*i+:DLY_W];
    assign trip[i] = cond[i] & (pins.zero_delay | (dly_cnt_reg[i] >= limit));
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        dly_cnt_reg[i] <= '0;
      end else if (!cond[i]) begin
        dly_cnt_reg[i] <= '0;
      end else if (tick && dly_cnt_reg[i] < limit) begin
        dly_cnt_reg[i] <= dly_cnt_reg[i] + 1'b1;
      end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        fault_reg[i] <= 1'b0;
      end else if (trip[i]) begin
        fault_reg[i] <= 1'b1;
      end else if (clr_pulse && recov[i]) begin
        fault_reg[i] <= 1'b0;
      end
    end
    assign event_vec[i] = trip[i] & ~fault_reg[i];
  end

  assign three_volt_regulator_lost = (pwr_reg == PWR_BAT) & ~pins.three_volt_regulator_good;
  assign event_vec[EV_PWR] = three_volt_regulator_lost;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_reg <= PWR_OFF;
    end else begin
      unique case (pwr_reg)
        PWR_OFF: if (pins.pack_startup) pwr_reg <= PWR_PACK;
        PWR_PACK: if (pins.five_volt_regulator_good && pins.three_volt_regulator_good) pwr_reg <= PWR_BAT;
        PWR_BAT: if (!pins.three_volt_regulator_good) pwr_reg <= PWR_OFF;
        default: pwr_reg <= PWR_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      if (access && avs_write_i && avs_address_i == ADDR_IRQ_STATUS) begin
        irq_status_reg <= event_vec | (irq_status_reg &
                          ~(avs_writedata_i[NEVT-1:0] & {NEVT{avs_byteenable_i[0]}}));
      end else begin
        irq_status_reg <= event_vec | irq_status_reg;
      end
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cell_count_reg <= CELLS_NONE;
      strap_reserved_reg <= 1'b0;
    end else begin
      cell_count_reg <= cpf_cell_count(pins.strap);
      strap_reserved_reg <= (pins.strap > STRAP_FIVE);
    end
  end

  // enables alone do not switch: an open latch or a weak supply overrides
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      charge_switch_o <= 1'b0;
      discharge_switch_o <= 1'b0;
    end else begin
      charge_switch_o <= (pwr_reg == PWR_BAT) & ctrl_reg.chg_en &
                         ~fault_reg[F_OV] & ~fault_reg[F_OCD] & ~fault_reg[F_SCD];
      discharge_switch_o <= (pwr_reg == PWR_BAT) & ctrl_reg.dsg_en &
                            ~fault_reg[F_UV] & ~fault_reg[F_OCD] & ~fault_reg[F_SCD];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      five_volt_regulator_en_o <= 1'b0;
      three_volt_regulator_en_o <= 1'b0;
      reg_source_bat_o <= 1'b0;
      thermistor_drive_o <= 1'b0;
    end else begin
      five_volt_regulator_en_o <= (pwr_reg != PWR_OFF);
      three_volt_regulator_en_o <= (pwr_reg != PWR_OFF);
      reg_source_bat_o <= (pwr_reg == PWR_BAT);
      thermistor_drive_o <= (pwr_reg == PWR_BAT) & ctrl_reg.thermistor_drive_en;
    end
  end

  // pack monitor beats battery monitor, both beat calibration and cells
  always_comb begin
    route_next = VR_GROUND;
    if (ctrl_reg.amp_en) begin
      if (ctrl_reg.pack_mon) begin
        route_next = VR_PACK;
      end else if (ctrl_reg.bat_mon) begin
        route_next = VR_BAT;
      end else if (ctrl_reg.cell_sel != '0) begin
        route_next = VR_CELL;
      end else begin
        unique case (ctrl_reg.cal_sel)
          CAL_AMP_ZERO: route_next = VR_AMP_ZERO;
          CAL_REF_AMP: route_next = VR_REF_AMP;
          CAL_REF_DIRECT: route_next = VR_REF_DIRECT;
          CAL_HI_AMP: route_next = VR_HI_AMP;
          CAL_REF_HOLD: route_next = VR_REF_HOLD;
          CAL_HI_HOLD: route_next = VR_HI_HOLD;
          default: route_next = VR_GROUND;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vout_route_o <= VR_GROUND;
      cell_select_o <= '0;
      cell_gain_select_o <= 1'b0;
    end else begin
      vout_route_o <= route_next;
      cell_select_o <= ctrl_reg.cell_sel;
      cell_gain_select_o <= ctrl_reg.gain_sel;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_ov_chg_off: assert property (fault_reg[F_OV] |=> !charge_switch_o)
    else $error("charge on during overvoltage");
  chk_ov_dsg_kept: assert property (pwr_reg == PWR_BAT && ctrl_reg.dsg_en &&
    fault_reg == 4'h1 |=> discharge_switch_o) else $error("discharge dropped on overvoltage");
  chk_ov_recover: assert property (clr_pulse && pins.ov_all_below && !trip[F_OV]
    |=> !fault_reg[F_OV]) else $error("overvoltage not recovered");
  chk_uv_dsg_off: assert property (fault_reg[F_UV] |=> !discharge_switch_o)
    else $error("discharge on during undervoltage");
  chk_uv_recover: assert property (clr_pulse && !trip[F_UV] && recov[F_UV]
    |=> !fault_reg[F_UV]) else $error("undervoltage not recovered");
  chk_oc_both_off: assert property (fault_reg[F_OCD] |=>
    !charge_switch_o && !discharge_switch_o) else $error("switch on during overcurrent");
  chk_sc_held: assert property (fault_reg[F_SCD] && !clr_pulse |=> fault_reg[F_SCD])
    else $error("short circuit cleared alone");
  chk_unpowered_off: assert property (pwr_reg != PWR_BAT |=>
    !charge_switch_o && !discharge_switch_o) else $error("switch on while unpowered");
  chk_source_move: assert property (pwr_reg == PWR_PACK && pins.five_volt_regulator_good &&
    pins.three_volt_regulator_good |=> ##1 reg_source_bat_o) else $error("source not moved to battery");
  chk_three_volt_regulator_shutdown: assert property (three_volt_regulator_lost |=> pwr_reg == PWR_OFF ##1
    (!three_volt_regulator_en_o && !thermistor_drive_o)) else $error("no shutdown on loss");
  chk_cells_decode: assert property (pins.strap == STRAP_TEN |=>
    cell_count_reg == CELLS_MAX) else $error("ten cell strap misdecoded");
  chk_strap_reserved: assert property (pins.strap[2:1] == 2'b11 |=>
    strap_reserved_reg && cell_count_reg == CELLS_NONE) else $error("reserved strap missed");
  chk_zero_delay: assert property (pins.zero_delay && cond[F_OCD] |=>
    fault_reg[F_OCD]) else $error("zero delay not immediate");
  chk_route_ground: assert property (!ctrl_reg.amp_en |=> vout_route_o == VR_GROUND)
    else $error("output not grounded");
  chk_route_pack: assert property (ctrl_reg.amp_en && ctrl_reg.pack_mon |=>
    vout_route_o == VR_PACK) else $error("pack monitor not routed");
  chk_route_cal: assert property (ctrl_reg.amp_en && !ctrl_reg.pack_mon &&
    !ctrl_reg.bat_mon && ctrl_reg.cell_sel == '0 && ctrl_reg.cal_sel == CAL_REF_DIRECT
    |=> vout_route_o == VR_REF_DIRECT) else $error("direct reference not routed");
  chk_uv_chg_kept: assert property (pwr_reg == PWR_BAT && ctrl_reg.chg_en &&
    fault_reg == 4'h2 |=> charge_switch_o) else $error("charge dropped on undervoltage");
  chk_oc_release: assert property (clr_pulse && !trip[F_OCD] |=> !fault_reg[F_OCD])
    else $error("overcurrent latch not released");
  chk_sc_both_off: assert property (fault_reg[F_SCD] |=>
    !charge_switch_o && !discharge_switch_o) else $error("switch on during short circuit");
  chk_route_bat: assert property (ctrl_reg.amp_en && !ctrl_reg.pack_mon &&
    ctrl_reg.bat_mon |=> vout_route_o == VR_BAT) else $error("battery monitor not routed");

  cov_ov_trip: cover property (event_vec[F_OV]);
  cov_uv_clear: cover property (clr_pulse && fault_reg[F_UV] ##1 !fault_reg[F_UV]);
  cov_power_up: cover property (pwr_reg == PWR_PACK ##1 pwr_reg == PWR_BAT);
  cov_cal_hold: cover property (vout_route_o == VR_HI_HOLD);
  cov_sc_recover: cover property (clr_pulse && fault_reg[F_SCD] ##1 !fault_reg[F_SCD]);
endmodule
`default_nettype wire

/* File: test/cpf_host_model.sv */
// host side model: register master and fault recovery sequence
`timescale 1ns/1ps
`default_nettype none
module cpf_host_model
  import cpf_pkg::*;
(
  input wire logic clk_i,
  output logic [4:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i
);
  initial begin
    address_o = 5'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'hf;
  end

  // request held until waitrequest is seen low; only the bench watchdog ends a hang
  task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    address_o <= a;
    read_o <= !w;
    write_o <= w;
    writedata_o <= d;
    byteenable_o <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask

  // enables stay low while latch clear toggles, else a latched fault could be re-armed
  task automatic recover(input logic [31:0] base);
    logic [31:0] q;
    xfer(ADDR_CTRL, 1'b1, (base & ~32'h3) | 32'h4, q);
    xfer(ADDR_CTRL, 1'b1, base & ~32'h7, q);
    xfer(ADDR_CTRL, 1'b1, (base & ~32'h4) | 32'h3, q);
  endtask

  function automatic real amp_scale(input real zero_in, input real ref_amp, input real ref_dir);
    amp_scale = (zero_in - ref_amp) / ref_dir;
  endfunction
endmodule
`default_nettype wire

/* File: test/tb_cpf_fault_ctl.sv */
// testbench of the cell protection fault controller
`timescale 1ns/1ps
`default_nettype none
module tb_cpf_fault_ctl;
  import cpf_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    cpf_route_type route;
    logic gain;
  } cpf_row_type;
  cpf_row_type rows [12] = '{'{32'h0010, VR_GROUND, 1'b0}, '{32'h0050, VR_PACK, 1'b0},
    '{32'h0060, VR_BAT, 1'b0}, '{32'h0070, VR_PACK, 1'b0}, '{32'h1848, VR_CELL, 1'b1},
    '{32'h0140, VR_AMP_ZERO, 1'b0}, '{32'h0240, VR_REF_AMP, 1'b0},
    '{32'h0340, VR_REF_DIRECT, 1'b0}, '{32'h0440, VR_HI_AMP, 1'b0},
    '{32'h0540, VR_REF_HOLD, 1'b0}, '{32'h0640, VR_HI_HOLD, 1'b0}, '{32'h0008, VR_GROUND, 1'b1}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  cpf_pins_type pins;
  logic [4:0] addr;
  logic rd_s, wr_s, wreq, charge_switch, discharge_switch, r1, r2, rsrc, thermistor_drive, gain, irq;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be, csel;
  cpf_route_type route;
  int failures = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  cpf_host_model i_cpf_host_model (.clk_i(clk), .address_o(addr), .read_o(rd_s),
    .write_o(wr_s), .writedata_o(wdata), .byteenable_o(be), .readdata_i(rdata),
    .waitrequest_i(wreq));

  cpf_fault_ctl i_cpf_fault_ctl (.ref_clk_i(clk), .resetn_i(resetn), .avs_address_i(addr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .cell_overvoltage_i(pins.ov),
    .ov_all_below_i(pins.ov_all_below), .cell_undervoltage_i(pins.uv),
    .uv_above_hyst_i(pins.uv_above_hyst), .uv_above_i(pins.uv_above),
    .pack_over_bat_i(pins.pack_over_bat), .discharge_overcurrent_i(pins.discharge_overcurrent),
    .discharge_short_circuit_i(pins.discharge_short_circuit), .pack_startup_i(pins.pack_startup),
    .five_volt_regulator_good_i(pins.five_volt_regulator_good), .three_volt_regulator_good_i(pins.three_volt_regulator_good),
    .cell_count_strap_high_i(pins.strap[2]), .cell_count_strap_mid_i(pins.strap[1]),
    .cell_count_strap_low_i(pins.strap[0]), .zero_delay_select_i(pins.zero_delay),
    .charge_switch_o(charge_switch), .discharge_switch_o(discharge_switch), .five_volt_regulator_en_o(r1),
    .three_volt_regulator_en_o(r2), .reg_source_bat_o(rsrc), .thermistor_drive_o(thermistor_drive),
    .vout_route_o(route), .cell_select_o(csel), .cell_gain_select_o(gain), .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_cpf_host_model.xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    i_cpf_host_model.xfer(a, 1'b0, 32'h0, r);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run is under a thousand cycles, so this only trips on a hang
  initial begin
    #80000;
    failures++;
    end_of_test();
  end

  initial begin
    pins = '0;
    pins.ov_all_below = 1'b1;
    pins.uv_above_hyst = 1'b1;
    pins.uv_above = 1'b1;
    pins.zero_delay = 1'b1;
    cyc(4);
    resetn <= 1'b1;
    chk({charge_switch, discharge_switch, r1, r2, rsrc, thermistor_drive, irq, route}, 0, "reset outputs");
    chk(wreq, 1'b1, "reset waitrequest");
    for (int s = 0; s < 8; s++) begin
      pins.strap <= 3'(s);
      cyc(4);
      rd(ADDR_STATUS, q);
      chk(q[8:4], (s < 6) ? 5'(10 - s) : 5'h10, "strap decode");
    end
    pins.strap <= 3'h0;
    wr(ADDR_CTRL, 32'h3);
    cyc(3);
    chk({charge_switch, discharge_switch}, 2'b00, "switches before power");
    pins.pack_startup <= 1'b1;
    cyc(6);
    chk(rsrc, 1'b0, "source pack at start");
    pins.five_volt_regulator_good <= 1'b1;
    pins.three_volt_regulator_good <= 1'b1;
    cyc(10);
    rd(ADDR_STATUS, q);
    chk({q[11:10], rsrc}, 3'b111, "source battery");
    rd(ADDR_DELAY, q);
    chk(q, DELAY_RESET, "delay reset");
    rd(5'h1c, q);
    chk(q, 0, "unmapped read");
    wr(ADDR_IRQ_MASK, 32'h1f);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, rows[i].ctrl | 32'h3);
      cyc(2);
      chk({route, gain, csel, charge_switch, discharge_switch}, {rows[i].route, rows[i].gain, rows[i].ctrl[14:11], 2'b11},
          "monitor route");
    end
    pins.ov <= 1'b1;
    pins.ov_all_below <= 1'b0;
    cyc(6);
    chk({charge_switch, discharge_switch, irq}, 3'b011, "overvoltage trip");
    pins.ov <= 1'b0;
    pins.ov_all_below <= 1'b1;
    cyc(6);
    chk({charge_switch, discharge_switch}, 2'b01, "overvoltage held");
    i_cpf_host_model.recover(32'h0);
    cyc(2);
    chk({charge_switch, discharge_switch}, 2'b11, "overvoltage recovery");
    wr(ADDR_IRQ_STATUS, 32'h1f);
    wr(ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk(irq, 1'b0, "irq cleared");
    pins.discharge_overcurrent <= 1'b1;
    cyc(6);
    chk({charge_switch, discharge_switch, irq}, 3'b000, "overcurrent trip masked");
    rd(ADDR_IRQ_STATUS, q);
    chk(q[4:0], 5'h04, "overcurrent status");
    wr(ADDR_IRQ_MASK, 32'h1f);
    pins.discharge_overcurrent <= 1'b0;
    cyc(30);
    chk({charge_switch, discharge_switch, irq}, 3'b001, "no current recovery");
    i_cpf_host_model.recover(32'h0);
    wr(ADDR_IRQ_STATUS, 32'h1f);
    pins.discharge_short_circuit <= 1'b1;
    cyc(6);
    chk({charge_switch, discharge_switch}, 2'b00, "short circuit trip");
    pins.discharge_short_circuit <= 1'b0;
    i_cpf_host_model.recover(32'h0);
    cyc(2);
    chk({charge_switch, discharge_switch}, 2'b11, "short circuit recovery");
    pins.zero_delay <= 1'b0;
    // two ticks: the trip cannot land before the first look, whatever the tick phase
    wr(ADDR_DELAY, 32'h0a0a_020a);
    pins.uv <= 1'b1;
    pins.uv_above_hyst <= 1'b0;
    pins.uv_above <= 1'b0;
    cyc(150);
    chk({charge_switch, discharge_switch}, 2'b11, "undervoltage delayed");
    cyc(400);
    chk({charge_switch, discharge_switch}, 2'b10, "undervoltage trip");
    pins.uv <= 1'b0;
    pins.uv_above <= 1'b1;
    pins.pack_over_bat <= 1'b1;
    cyc(6);
    i_cpf_host_model.recover(32'h80);
    cyc(2);
    chk({charge_switch, discharge_switch, thermistor_drive}, 3'b111, "undervoltage recovery");
    pins.three_volt_regulator_good <= 1'b0;
    // pack removed too, else the sequencer restarts from the pack at once
    pins.pack_startup <= 1'b0;
    cyc(6);
    chk({charge_switch, discharge_switch, r1, r2, thermistor_drive}, 5'h00, "regulator loss");
    rd(ADDR_IRQ_STATUS, q);
    chk(q[4], 1'b1, "regulator loss status");
    end_of_test();
  end
endmodule
`default_nettype wire
